// >>> hsc_pkg.sv
// Constants shared by the histogram scan controller and its scan buffer
// Notes on behaviour
// R01: Point count equals final mass minus initial mass plus one.
// R02: Every ion current is four bytes; host expects four bytes per point.
// R03: Point-count answer leaves out the trailing total-pressure value.
// R04: Point-count command takes only the query form; anything else is bad parameter.
// R05: Currents go out as four-byte two's complement words, low byte first.
// R06: New command during a scan stops it, flushes transmit data, then executes.
// R07: Each scan starts with a detector zero and scan parameter correction.
// R08: After the last mass each scan measures and sends total pressure.
// R09: Scan trigger without parameter repeats scans until a new command.
// R10: Scan trigger with zero does nothing; it only interrupts scanning.
// R11: Scan trigger with 1 to 255 runs exactly that many scans.
// R12: Scan trigger with default marker runs a single scan.
// R13: Scan trigger refuses values above 255 and the query form.
// R14: Scan uses the detector selected when it was triggered.
// R15: Whole scan is buffered; next scan waits until pending data is sent.
// R16: Final mass accepts 1 to maximum mass and can be queried.
// R17: Maximum mass is 100, 200 or 300, bounding both mass settings.
// R18: Default marker sets the final mass to the maximum mass.
// R19: Final mass below initial mass is refused with a conflict error.
// R20: Default marker sets initial mass to one; range 1 to maximum.
// R21: Initial mass above final mass is refused with a conflict error.
// R22: Mass commands without parameter give bad parameter, setting unchanged.
package hsc_pkg;
  localparam int MASS_W = 9;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTES_PER_WORD = 4;
  localparam logic [2:0] BYTES_PER_WORD_3 = 3'h4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COMMAND   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INIT_MASS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FINAL_MASS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_POINTS    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DETECTOR  = 8'h14;

  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_FORM_LSB = 4;
  localparam int CMD_VAL_LSB  = 16;

  typedef enum logic [3:0] {
    HSC_OP_POINTS_QUERY = 4'h1,
    HSC_OP_SCAN_TRIGGER = 4'h2,
    HSC_OP_FINAL_MASS   = 4'h3,
    HSC_OP_INIT_MASS    = 4'h4
  } hsc_op_type;

  typedef enum logic [1:0] {
    HSC_FORM_NONE    = 2'h0,
    HSC_FORM_NUMBER  = 2'h1,
    HSC_FORM_DEFAULT = 2'h2,
    HSC_FORM_QUERY   = 2'h3
  } hsc_form_type;

  // Status bits
  localparam int ST_SCANNING  = 0;
  localparam int ST_BAD_PARAM = 1;
  localparam int ST_CONFLICT  = 2;
  localparam int ST_BAD_CMD   = 3;
  localparam int ST_TX_EMPTY  = 4;

  localparam logic [MASS_W-1:0] INIT_MASS_DEFAULT = 9'h001;
  localparam logic [MASS_W-1:0] MASS_MIN          = 9'h001;
  localparam logic [8:0]        SCAN_COUNT_MAX    = 9'h0FF;
  localparam logic [7:0]        SCAN_COUNT_SINGLE = 8'h01;
endpackage

// >>> hsc_scan_buffer.sv
// Scan buffer holding whole scans and sending words low byte first
`timescale 1ns/1ns
module hsc_scan_buffer #(
  parameter int DEPTH = 301
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      flush,
  input  wire logic                      wr_valid,
  input  wire logic [hsc_pkg::WORD_W-1:0] wr_data,
  output logic                           wr_ready,
  output logic                           tx_valid,
  input  wire logic                      tx_ready,
  output logic [7:0]                     tx_data,
  output logic                           empty
);
  localparam int PTR_W = $clog2(DEPTH);

  generate
    if (DEPTH < 2)
    begin : g_bad_depth
      $error("DEPTH must be at least 2");
    end
  endgenerate

  logic [hsc_pkg::WORD_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]           wr_ptr;
  logic [PTR_W-1:0]           rd_ptr;
  logic [PTR_W:0]             count;
  logic [hsc_pkg::WORD_W-1:0] shift;
  logic [2:0]                 bytes_left;
  logic                       load;
  logic                       push;

  assign wr_ready = (count != (PTR_W+1)'(DEPTH)) || load;
  assign push     = wr_valid && (count != (PTR_W+1)'(DEPTH));
  assign load     = (bytes_left == 3'h0) && (count != '0) && !flush;
  assign tx_valid = bytes_left != 3'h0;
  assign tx_data  = shift[7:0];
  assign empty    = (count == '0) && (bytes_left == 3'h0);

  always_ff @(posedge clk)
  begin
    if (push && !flush)
      mem[wr_ptr] <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
      if (load)
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(load);
    end
  end

  // Word goes out low byte first [R05]
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      shift      <= '0;
      bytes_left <= 3'h0;
    end
    else if (load)
    begin
      shift      <= mem[rd_ptr];
      bytes_left <= hsc_pkg::BYTES_PER_WORD_3; // [R02]
    end
    else if (tx_valid && tx_ready)
    begin
      shift      <= shift >> 8;
      bytes_left <= bytes_left - 3'h1;
    end
  end

  property p_flush_clears;
    @(posedge clk) disable iff (rst) flush |=> empty && !tx_valid;
  endproperty
  a_flush_clears: assert property (p_flush_clears) else $error("buffer not empty after flush"); // [R06]

  property p_four_bytes;
    @(posedge clk) disable iff (rst || flush) load |=> bytes_left == hsc_pkg::BYTES_PER_WORD_3;
  endproperty
  a_four_bytes: assert property (p_four_bytes) else $error("word not four bytes"); // [R02]
endmodule // hsc_scan_buffer

// >>> hsc_scan_control.sv
// Histogram scan command interpreter with mass settings and scan sequencing
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module hsc_scan_control #(
  parameter int M_MAX = 300
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [hsc_pkg::ADDR_W-1:0]   addr,
  input  wire logic [hsc_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [hsc_pkg::DATA_W-1:0]   rdata,
  output logic                              cal_req,
  input  wire logic                         cal_done,
  output logic                              meas_req,
  output logic                              meas_total,
  output logic      [hsc_pkg::MASS_W-1:0]   meas_mass,
  output logic                              meas_detector,
  output logic                              meas_abort,
  input  wire logic                         meas_done,
  input  wire logic [hsc_pkg::WORD_W-1:0]   meas_data,
  output logic                              tx_valid,
  input  wire logic                         tx_ready,
  output logic      [7:0]                   tx_data
);
  localparam logic [hsc_pkg::MASS_W-1:0] MASS_LIMIT = hsc_pkg::MASS_W'(M_MAX);

  generate
    if (M_MAX != 100 && M_MAX != 200 && M_MAX != 300)
    begin : g_bad_max
      $error("M_MAX must be 100, 200 or 300");
    end
  endgenerate

  typedef enum logic [2:0] {
    HSC_IDLE       = 3'h0,
    HSC_FLUSH      = 3'h1,
    HSC_WAIT_EMPTY = 3'h2,
    HSC_CAL        = 3'h3,
    HSC_MEAS       = 3'h4,
    HSC_TOTAL      = 3'h5,
    HSC_NEXT       = 3'h6
  } hsc_state_type;

  hsc_state_type                state;
  logic                         pending;
  logic [3:0]                   pend_op;
  hsc_pkg::hsc_form_type        pend_form;
  logic [15:0]                  pend_val;
  logic [hsc_pkg::MASS_W-1:0]   init_mass;
  logic [hsc_pkg::MASS_W-1:0]   final_mass;
  logic [hsc_pkg::MASS_W-1:0]   points;
  logic [hsc_pkg::MASS_W-1:0]   cur_mass;
  logic [7:0]                   scans_left;
  logic                         continuous;
  logic                         detector_sel;
  logic                         scan_detector;
  logic                         bad_param;
  logic                         conflict;
  logic                         bad_cmd;
  logic                         set_bad_param;
  logic                         set_conflict;
  logic                         set_bad_cmd;
  logic                         cmd_write;
  logic                         decode;
  logic                         scanning;
  logic                         flush;
  logic                         buf_empty;
  logic                         buf_wr;
  logic [hsc_pkg::MASS_W-1:0]   next_points;
  logic [hsc_pkg::MASS_W-1:0]   num_mass;

  assign cmd_write   = wr && (addr == hsc_pkg::OFS_COMMAND);
  assign decode      = (state == HSC_IDLE) && pending;
  assign scanning    = (state != HSC_IDLE) && (state != HSC_FLUSH);
  assign flush       = state == HSC_FLUSH;
  assign next_points = final_mass - init_mass + hsc_pkg::MASS_W'(1); // [R01]
  assign num_mass    = pend_val[hsc_pkg::MASS_W-1:0];
  assign buf_wr      = meas_done && ((state == HSC_MEAS) || (state == HSC_TOTAL));
  assign meas_abort  = flush;
  assign meas_mass   = cur_mass;
  assign meas_detector = scan_detector;

  // Latest command waits here until the sequencer is free to decode it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pending   <= 1'b0;
      pend_op   <= 4'h0;
      pend_form <= hsc_pkg::HSC_FORM_NONE;
      pend_val  <= 16'h0000;
    end
    else if (cmd_write)
    begin
      pending   <= 1'b1;
      pend_op   <= wdata[hsc_pkg::CMD_OP_LSB +: 4];
      pend_form <= hsc_pkg::hsc_form_type'(wdata[hsc_pkg::CMD_FORM_LSB +: 2]);
      pend_val  <= wdata[hsc_pkg::CMD_VAL_LSB +: 16];
    end
    else if (decode)
      pending <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      detector_sel <= 1'b0;
    else if (wr && addr == hsc_pkg::OFS_DETECTOR)
      detector_sel <= wdata[0];
  end

  // Decode outcome flags
  always_comb
  begin
    set_bad_param = 1'b0;
    set_conflict  = 1'b0;
    set_bad_cmd   = 1'b0;
    if (decode)
    begin
      unique case (pend_op)
        hsc_pkg::HSC_OP_POINTS_QUERY:
          set_bad_param = pend_form != hsc_pkg::HSC_FORM_QUERY; // [R04]
        hsc_pkg::HSC_OP_SCAN_TRIGGER:
          set_bad_param = (pend_form == hsc_pkg::HSC_FORM_QUERY) ||
                          (pend_form == hsc_pkg::HSC_FORM_NUMBER &&
                           pend_val > 16'(hsc_pkg::SCAN_COUNT_MAX)); // [R13]
        hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_OP_INIT_MASS:
        begin
          set_bad_param = (pend_form == hsc_pkg::HSC_FORM_NONE) || // [R22]
                          (pend_form == hsc_pkg::HSC_FORM_NUMBER &&
                           (pend_val < 16'(hsc_pkg::MASS_MIN) ||
                            pend_val > 16'(MASS_LIMIT))); // [R16] [R17] [R20]
          if (pend_form == hsc_pkg::HSC_FORM_NUMBER && !set_bad_param)
            set_conflict = (pend_op == hsc_pkg::HSC_OP_FINAL_MASS) ?
                           (num_mass < init_mass) : // [R19]
                           (num_mass > final_mass); // [R21]
        end
        default:
          set_bad_cmd = 1'b1;
      endcase
    end
  end

  // Mass settings change only on a clean command
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      init_mass  <= hsc_pkg::INIT_MASS_DEFAULT;
      final_mass <= MASS_LIMIT;
    end
    else if (decode && !set_bad_param && !set_conflict)
    begin
      if (pend_op == hsc_pkg::HSC_OP_FINAL_MASS)
      begin
        if (pend_form == hsc_pkg::HSC_FORM_DEFAULT)
          final_mass <= MASS_LIMIT; // [R18]
        else if (pend_form == hsc_pkg::HSC_FORM_NUMBER)
          final_mass <= num_mass; // [R16]
      end
      if (pend_op == hsc_pkg::HSC_OP_INIT_MASS)
      begin
        if (pend_form == hsc_pkg::HSC_FORM_DEFAULT)
          init_mass <= hsc_pkg::INIT_MASS_DEFAULT; // [R20]
        else if (pend_form == hsc_pkg::HSC_FORM_NUMBER)
          init_mass <= num_mass; // [R20]
      end
    end
  end

  // Count excludes the trailing total-pressure word
  always_ff @(posedge clk)
  begin
    if (rst)
      points <= '0;
    else if (decode && !set_bad_param && pend_op == hsc_pkg::HSC_OP_POINTS_QUERY)
      points <= next_points; // [R01] [R03]
  end

  // Hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bad_param <= 1'b0;
      conflict  <= 1'b0;
      bad_cmd   <= 1'b0;
    end
    else
    begin
      if (wr && addr == hsc_pkg::OFS_STATUS)
      begin
        bad_param <= set_bad_param | (bad_param & ~wdata[hsc_pkg::ST_BAD_PARAM]);
        conflict  <= set_conflict  | (conflict  & ~wdata[hsc_pkg::ST_CONFLICT]);
        bad_cmd   <= set_bad_cmd   | (bad_cmd   & ~wdata[hsc_pkg::ST_BAD_CMD]);
      end
      else
      begin
        bad_param <= bad_param | set_bad_param;
        conflict  <= conflict | set_conflict;
        bad_cmd   <= bad_cmd | set_bad_cmd;
      end
    end
  end

  // Scan sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state         <= HSC_IDLE;
      scans_left    <= 8'h00;
      continuous    <= 1'b0;
      scan_detector <= 1'b0;
      cur_mass      <= hsc_pkg::INIT_MASS_DEFAULT;
    end
    else if (pending && scanning)
      state <= HSC_FLUSH; // [R06]
    else
    begin
      unique case (state)
        HSC_IDLE:
          if (decode && !set_bad_param && pend_op == hsc_pkg::HSC_OP_SCAN_TRIGGER)
          begin
            scan_detector <= detector_sel; // [R14]
            continuous    <= pend_form == hsc_pkg::HSC_FORM_NONE; // [R09]
            if (pend_form == hsc_pkg::HSC_FORM_NONE)
              state <= HSC_WAIT_EMPTY;
            else if (pend_form == hsc_pkg::HSC_FORM_DEFAULT)
            begin
              scans_left <= hsc_pkg::SCAN_COUNT_SINGLE; // [R12]
              state      <= HSC_WAIT_EMPTY;
            end
            else if (pend_val[7:0] != 8'h00)
            begin
              scans_left <= pend_val[7:0]; // [R11]
              state      <= HSC_WAIT_EMPTY;
            end
            // Zero count leaves the sequencer idle [R10]
          end
        HSC_FLUSH:
          state <= HSC_IDLE; // [R06]
        HSC_WAIT_EMPTY:
          if (buf_empty)
          begin
            cur_mass <= init_mass;
            state    <= HSC_CAL; // [R15]
          end
        HSC_CAL:
          if (cal_done)
            state <= HSC_MEAS; // [R07]
        HSC_MEAS:
          if (meas_done)
          begin
            if (cur_mass == final_mass)
              state <= HSC_TOTAL; // [R08]
            else
              cur_mass <= cur_mass + hsc_pkg::MASS_W'(1);
          end
        HSC_TOTAL:
          if (meas_done)
          begin
            if (!continuous)
              scans_left <= scans_left - 8'h01; // [R11]
            state <= HSC_NEXT;
          end
        HSC_NEXT:
          state <= (continuous || scans_left != 8'h00) ? HSC_WAIT_EMPTY : HSC_IDLE; // [R09]
        default:
          state <= HSC_IDLE;
      endcase
    end
  end

  // Requests stand until the matching done
  always_comb
  begin
    cal_req    = state == HSC_CAL;
    meas_req   = (state == HSC_MEAS) || (state == HSC_TOTAL);
    meas_total = state == HSC_TOTAL;
  end

  // Depth covers a full scan plus its pressure word
  hsc_scan_buffer #(
    .DEPTH (M_MAX + 1)
  ) u_buffer (
    .clk      (clk),
    .rst      (rst),
    .flush    (flush),
    .wr_valid (buf_wr),
    .wr_data  (meas_data),
    .wr_ready (),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_data  (tx_data),
    .empty    (buf_empty)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= '0;
    else if (rd)
    begin
      unique case (addr)
        hsc_pkg::OFS_STATUS:
          rdata <= hsc_pkg::DATA_W'({buf_empty, bad_cmd, conflict, bad_param, scanning});
        hsc_pkg::OFS_INIT_MASS:
          rdata <= hsc_pkg::DATA_W'(init_mass);
        hsc_pkg::OFS_FINAL_MASS:
          rdata <= hsc_pkg::DATA_W'(final_mass); // [R16]
        hsc_pkg::OFS_POINTS:
          rdata <= hsc_pkg::DATA_W'(points); // [R03]
        hsc_pkg::OFS_DETECTOR:
          rdata <= hsc_pkg::DATA_W'(detector_sel);
        default:
          rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  property p_points;
    @(posedge clk) disable iff (rst)
      decode && pend_op == hsc_pkg::HSC_OP_POINTS_QUERY && pend_form == hsc_pkg::HSC_FORM_QUERY
      |=> points == final_mass - init_mass + hsc_pkg::MASS_W'(1);
  endproperty
  a_points: assert property (p_points) else $error("point count wrong"); // [R01]

  property p_points_bad;
    @(posedge clk) disable iff (rst)
      decode && pend_op == hsc_pkg::HSC_OP_POINTS_QUERY && pend_form != hsc_pkg::HSC_FORM_QUERY
      |=> bad_param && $stable(points);
  endproperty
  a_points_bad: assert property (p_points_bad) else $error("point form not refused"); // [R04]

  property p_abort;
    @(posedge clk) disable iff (rst) pending && scanning |=> flush ##1 state == HSC_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("command did not abort scan"); // [R06]

  property p_cal_first;
    @(posedge clk) disable iff (rst)
      state == HSC_WAIT_EMPTY && buf_empty && !pending |=> cal_req && !meas_req;
  endproperty
  a_cal_first: assert property (p_cal_first) else $error("scan skipped zero check"); // [R07]

  property p_total_after_last;
    @(posedge clk) disable iff (rst || pending)
      state == HSC_MEAS && meas_done && cur_mass == final_mass |=> meas_total;
  endproperty
  a_total_after_last: assert property (p_total_after_last) else $error("no total pressure"); // [R08]

  property p_zero_idle;
    @(posedge clk) disable iff (rst)
      decode && pend_op == hsc_pkg::HSC_OP_SCAN_TRIGGER
      && pend_form == hsc_pkg::HSC_FORM_NUMBER && pend_val == 16'h0000
      |=> state == HSC_IDLE;
  endproperty
  a_zero_idle: assert property (p_zero_idle) else $error("zero trigger started scan"); // [R10]

  property p_scan_query_bad;
    @(posedge clk) disable iff (rst)
      decode && pend_op == hsc_pkg::HSC_OP_SCAN_TRIGGER && pend_form == hsc_pkg::HSC_FORM_QUERY
      |=> bad_param && state == HSC_IDLE;
  endproperty
  a_scan_query_bad: assert property (p_scan_query_bad) else $error("query trigger accepted"); // [R13]

  property p_wait_empty;
    @(posedge clk) disable iff (rst) state == HSC_WAIT_EMPTY && !buf_empty |=> !cal_req;
  endproperty
  a_wait_empty: assert property (p_wait_empty) else $error("scan began with data pending"); // [R15]

  property p_final_conflict;
    @(posedge clk) disable iff (rst)
      decode && pend_op == hsc_pkg::HSC_OP_FINAL_MASS && pend_form == hsc_pkg::HSC_FORM_NUMBER
      && num_mass < init_mass && pend_val >= 16'h0001 && pend_val <= 16'(MASS_LIMIT)
      |=> conflict && $stable(final_mass);
  endproperty
  a_final_conflict: assert property (p_final_conflict) else $error("final conflict missed"); // [R19]

  property p_init_conflict;
    @(posedge clk) disable iff (rst)
      decode && pend_op == hsc_pkg::HSC_OP_INIT_MASS && pend_form == hsc_pkg::HSC_FORM_NUMBER
      && num_mass > final_mass && pend_val <= 16'(MASS_LIMIT)
      |=> conflict && $stable(init_mass);
  endproperty
  a_init_conflict: assert property (p_init_conflict) else $error("initial conflict missed"); // [R21]

  property p_mass_none;
    @(posedge clk) disable iff (rst)
      decode && (pend_op == hsc_pkg::HSC_OP_INIT_MASS || pend_op == hsc_pkg::HSC_OP_FINAL_MASS)
      && pend_form == hsc_pkg::HSC_FORM_NONE
      |=> bad_param && $stable(init_mass) && $stable(final_mass);
  endproperty
  a_mass_none: assert property (p_mass_none) else $error("missing mass parameter accepted"); // [R22]

  property p_detector_held;
    @(posedge clk) disable iff (rst) scanning && $past(scanning) |-> $stable(scan_detector);
  endproperty
  a_detector_held: assert property (p_detector_held) else $error("detector changed in scan"); // [R14]
endmodule // hsc_scan_control

// >>> hsc_meas_model.sv
// Measurement engine and serial host model facing the scan controller
`timescale 1ns/1ns
module hsc_meas_model (
  input  wire logic        clk,
  input  wire logic        cal_req,
  output logic             cal_done,
  input  wire logic        meas_req,
  input  wire logic        meas_total,
  input  wire logic [8:0]  meas_mass,
  input  wire logic        meas_abort,
  output logic             meas_done,
  output logic [31:0]      meas_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data
);
  logic [15:0] lfsr = 16'hC829;
  logic [31:0] words[$];
  logic [8:0]  masses[$];
  logic [7:0]  bytes[$];
  int          waited = 0;
  int          aborts = 0;
  initial
  begin
    cal_done = 1'b0;
    meas_done = 1'b0;
    meas_data = 32'h0;
    tx_ready = 1'b0;
  end
  always @(posedge clk)
  begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    cal_done <= 1'b0;
    meas_done <= 1'b0;
    // Idle data toggles so a stale word never passes for a fresh one
    meas_data <= ~meas_data;
    tx_ready <= lfsr[0] | lfsr[5];
    if (tx_valid && tx_ready)
      bytes.push_back(tx_data);
    if (meas_abort)
    begin
      aborts++;
      waited = 0;
    end
    else if ((cal_req || meas_req) && !cal_done && !meas_done)
    begin
      if (waited < int'(lfsr[3:2]))
        waited++;
      else
      begin
        waited = 0;
        cal_done <= cal_req;
        meas_done <= meas_req;
        masses.push_back(cal_req ? 9'h000 : (meas_total ? 9'h1FF : meas_mass));
        if (meas_req)
        begin
          meas_data <= {lfsr, lfsr ^ 16'h5A3C};
          words.push_back({lfsr, lfsr ^ 16'h5A3C});
        end
      end
    end
  end
endmodule // hsc_meas_model

// >>> test_histogram_scan_control.sv
// Self-checking bench for the histogram scan controller
`timescale 1ns/1ns
module test_histogram_scan_control;
  localparam int MMAX = 100;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] meas_data;
  logic [8:0]  meas_mass;
  logic [7:0]  tx_data;
  logic        cal_req, cal_done, meas_req, meas_total, meas_detector;
  logic        meas_abort, meas_done, tx_valid, tx_ready, det_exp;
  int          failures = 0;
  int          tests_run = 0;
  int          scan_bytes = 4;
  int          k;
  initial forever #5 clk = ~clk;
  hsc_scan_control #(.M_MAX(MMAX)) u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cal_req(cal_req), .cal_done(cal_done),
    .meas_req(meas_req), .meas_total(meas_total), .meas_mass(meas_mass),
    .meas_detector(meas_detector), .meas_abort(meas_abort), .meas_done(meas_done),
    .meas_data(meas_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  hsc_meas_model u_model (.clk(clk), .cal_req(cal_req), .cal_done(cal_done),
    .meas_req(meas_req), .meas_total(meas_total), .meas_mass(meas_mass),
    .meas_abort(meas_abort), .meas_done(meas_done), .meas_data(meas_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  task automatic close_out();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input string n, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata, e);
    @(posedge clk);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [1:0] form, input int v);
    wr_reg(hsc_pkg::OFS_COMMAND, {v[15:0], 10'h000, form, op});
    repeat (4) @(posedge clk);
  endtask
  // Reads one status flag, then clears all error flags for the next case
  task automatic flag(input int b);
    rd_reg(hsc_pkg::OFS_STATUS, "status flag", 32'h10 | (32'(1) << b));
    wr_reg(hsc_pkg::OFS_STATUS, 32'h0000000E);
  endtask
  task automatic settle(input int target, input bit by_mass);
    k = 0;
    while ((by_mass ? u_model.masses.size() : u_model.bytes.size()) < target && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20000)
    begin
      failures++;
      close_out();
    end
  endtask
  task automatic scan(input logic [1:0] form, input int v, input int n, input int mi,
                      input int mf, input logic d);
    int exp_m[$];
    scan_bytes = 4 * (mf - mi + 2);
    u_model.words.delete();
    u_model.masses.delete();
    u_model.bytes.delete();
    det_exp = d;
    wr_reg(hsc_pkg::OFS_DETECTOR, {31'h0, d});
    cmd(hsc_pkg::HSC_OP_SCAN_TRIGGER, form, v);
    wr_reg(hsc_pkg::OFS_DETECTOR, {31'h0, ~d});
    settle(n * scan_bytes, 1'b0);
    repeat (60) @(posedge clk);
    chk("byte count", u_model.bytes.size(), n * scan_bytes);
    for (int i = 0; i < n * scan_bytes; i++)
      chk("tx byte", u_model.bytes[i], (u_model.words[i/4] >> (8*(i%4))) & 32'hFF);
    repeat (n)
    begin
      exp_m.push_back(0);
      for (int m = mi; m <= mf; m++)
        exp_m.push_back(m);
      exp_m.push_back(32'h1FF);
    end
    chk("step count", u_model.masses.size(), exp_m.size());
    foreach (exp_m[i])
      chk("step mass", u_model.masses[i], exp_m[i]);
  endtask
  always @(posedge clk)
  begin
    if (meas_req && meas_done)
      chk("detector", meas_detector, det_exp);
    if (cal_req && cal_done)
      chk("pending bytes", u_model.bytes.size() % scan_bytes, 0);
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(hsc_pkg::OFS_INIT_MASS, "initial mass", 1);
    rd_reg(hsc_pkg::OFS_FINAL_MASS, "final mass", MMAX);
    cmd(hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_FORM_NUMBER, 5);
    cmd(hsc_pkg::HSC_OP_INIT_MASS, hsc_pkg::HSC_FORM_NUMBER, 3);
    cmd(hsc_pkg::HSC_OP_POINTS_QUERY, hsc_pkg::HSC_FORM_QUERY, 0);
    rd_reg(hsc_pkg::OFS_POINTS, "points", 3);
    cmd(hsc_pkg::HSC_OP_POINTS_QUERY, hsc_pkg::HSC_FORM_NONE, 0);
    flag(hsc_pkg::ST_BAD_PARAM);
    cmd(hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_FORM_NUMBER, 2);
    flag(hsc_pkg::ST_CONFLICT);
    cmd(hsc_pkg::HSC_OP_INIT_MASS, hsc_pkg::HSC_FORM_NUMBER, 6);
    flag(hsc_pkg::ST_CONFLICT);
    cmd(hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_FORM_NONE, 0);
    flag(hsc_pkg::ST_BAD_PARAM);
    rd_reg(hsc_pkg::OFS_FINAL_MASS, "final mass", 5);
    cmd(hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_FORM_NUMBER, MMAX + 1);
    flag(hsc_pkg::ST_BAD_PARAM);
    cmd(hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_FORM_DEFAULT, 0);
    rd_reg(hsc_pkg::OFS_FINAL_MASS, "final mass", MMAX);
    cmd(hsc_pkg::HSC_OP_INIT_MASS, hsc_pkg::HSC_FORM_NUMBER, MMAX);
    rd_reg(hsc_pkg::OFS_INIT_MASS, "initial mass", MMAX);
    cmd(hsc_pkg::HSC_OP_INIT_MASS, hsc_pkg::HSC_FORM_DEFAULT, 0);
    rd_reg(hsc_pkg::OFS_INIT_MASS, "initial mass", 1);
    cmd(hsc_pkg::HSC_OP_FINAL_MASS, hsc_pkg::HSC_FORM_NUMBER, 4);
    cmd(hsc_pkg::HSC_OP_INIT_MASS, hsc_pkg::HSC_FORM_NUMBER, 2);
    scan(hsc_pkg::HSC_FORM_NUMBER, 0, 0, 2, 4, 1'b0);
    scan(hsc_pkg::HSC_FORM_DEFAULT, 0, 1, 2, 4, 1'b1);
    scan(hsc_pkg::HSC_FORM_NUMBER, 3, 3, 2, 4, 1'b0);
    cmd(hsc_pkg::HSC_OP_SCAN_TRIGGER, hsc_pkg::HSC_FORM_NUMBER, 256);
    flag(hsc_pkg::ST_BAD_PARAM);
    cmd(hsc_pkg::HSC_OP_SCAN_TRIGGER, hsc_pkg::HSC_FORM_QUERY, 0);
    flag(hsc_pkg::ST_BAD_PARAM);
    u_model.masses.delete();
    u_model.bytes.delete();
    det_exp = 1'b1;
    cmd(hsc_pkg::HSC_OP_SCAN_TRIGGER, hsc_pkg::HSC_FORM_NONE, 0);
    settle(3 * 5 + 2, 1'b1);
    cmd(hsc_pkg::HSC_OP_SCAN_TRIGGER, hsc_pkg::HSC_FORM_NUMBER, 0);
    chk("aborts", u_model.aborts, 1);
    k = u_model.bytes.size();
    repeat (60) @(posedge clk);
    chk("bytes after flush", u_model.bytes.size(), k);
    rd_reg(hsc_pkg::OFS_STATUS, "status idle", 32'h10);
    close_out();
  end
endmodule // test_histogram_scan_control
